// *** cbli_line_if.sv ***
`timescale 1ns/10ps
`default_nettype none
module cbli_line_if (
    // clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    // wishbone slave
    input  wire logic                       cyc_i,
    input  wire logic                       stb_i,
    input  wire logic                       we_i,
    input  wire logic [cbli_pkg::ADR_W-1:0] adr_i,
    input  wire logic [3:0]                 sel_i,
    input  wire logic [cbli_pkg::DAT_W-1:0] dat_i,
    output logic      [cbli_pkg::DAT_W-1:0] dat_o,
    output logic                            ack_o,
    // can bus line pins
    input  wire logic                       bus_in_pos_i,
    input  wire logic                       bus_in_neg_i,
    output logic                            bus_out_a_o,
    output logic                            bus_out_b_o,
    // protocol side
    input  wire logic                       tx_bit_i,
    output logic                            rx_level_o,
    output logic                            rx_fall_o,
    output logic                            comparator_bypass_o
);

    // configuration and state
    logic [cbli_pkg::CFG_W-1:0] cfg_q;
    logic                       level_q;
    logic                       level_d;
    logic                       sticky_q;
    logic [cbli_pkg::CNT_W-1:0] edges_q;
    logic [1:0]                 pins_s;
    logic                       pos_s;
    logic                       neg_s;
    logic                       bypass;
    logic                       disconn;
    logic                       badcfg;
    logic                       access;
    logic                       wr_lane0;
    logic                       fall;
    logic [cbli_pkg::IDX_W-1:0] idx;

    // true when the word address selects the given register
    function automatic logic hit(
        input logic [cbli_pkg::ADR_W-1:0] adr,
        input logic [cbli_pkg::IDX_W-1:0] want
    );
        hit = (adr[cbli_pkg::ADR_W-1:cbli_pkg::IDX_LO] == want);
    endfunction : hit

    // bring both line pins into the clock domain
    cbli_sync #(
        .WIDTH (2)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({bus_in_neg_i, bus_in_pos_i}),
        .sync_o  (pins_s)
    );

    assign pos_s   = pins_s[0];
    assign neg_s   = pins_s[1];
    assign bypass  = cfg_q[cbli_pkg::CFG_BYPASS_BIT];
    assign disconn = cfg_q[cbli_pkg::CFG_DISCONN_BIT];
    assign idx     = adr_i[cbli_pkg::ADR_W-1:cbli_pkg::IDX_LO];

    // bypass with the pos input cut off leaves no line to read
    assign badcfg  = bypass & disconn;

    // a request is taken once; ack drops the cycle after
    assign access   = cyc_i & stb_i & ~ack_o;
    assign wr_lane0 = access & we_i & sel_i[0];

    // digital comparator; equal inputs hold the last level,
    // standing in for the analog hysteresis
    always_comb
    begin
        level_d = level_q;
        if (bypass)
        begin
            level_d = pos_s;
        end
        else if (pos_s & ~neg_s)
        begin
            level_d = cbli_pkg::LVL_RECESSIVE;
        end
        else if (neg_s & ~pos_s)
        begin
            level_d = cbli_pkg::LVL_DOMINANT;
        end
    end

    // recessive to dominant marks a possible sync edge
    assign fall = (level_q == cbli_pkg::LVL_RECESSIVE)
                  & (level_d == cbli_pkg::LVL_DOMINANT);

    // single received level for the bit timing logic
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            level_q    <= cbli_pkg::LVL_RECESSIVE;
            rx_level_o <= cbli_pkg::LVL_RECESSIVE;
            rx_fall_o  <= 1'b0;
        end
        else
        begin
            level_q    <= level_d;
            rx_level_o <= level_d;
            rx_fall_o  <= fall;
        end
    end

    // complementary line drivers, recessive while in reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bus_out_a_o <= 1'b1;
            bus_out_b_o <= 1'b0;
        end
        else if (tx_bit_i == cbli_pkg::LVL_RECESSIVE)
        begin
            bus_out_a_o <= 1'b1;
            bus_out_b_o <= 1'b0;
        end
        else
        begin
            bus_out_a_o <= 1'b0;
            bus_out_b_o <= 1'b1;
        end
    end

    // bus line configuration register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cfg_q               <= cbli_pkg::CFG_RESET;
            comparator_bypass_o <= 1'b0;
        end
        else if (wr_lane0 && hit(adr_i, cbli_pkg::IDX_BUS_LINE_CONFIG))
        begin
            cfg_q               <= dat_i[cbli_pkg::CFG_W-1:0];
            comparator_bypass_o <= dat_i[cbli_pkg::CFG_BYPASS_BIT];
        end
    end

    // sticky misconfiguration flag, write one clears, set wins
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sticky_q <= 1'b0;
        end
        else if (badcfg)
        begin
            sticky_q <= 1'b1;
        end
        else if (wr_lane0 && hit(adr_i, cbli_pkg::IDX_LINE_STATUS)
                 && dat_i[cbli_pkg::STS_STICKY_BIT])
        begin
            sticky_q <= 1'b0;
        end
    end

    // dominant edge counter, wraps; any write clears, a write and edge in one cycle load one
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            edges_q <= cbli_pkg::CNT_RESET;
        end
        else if (fall)
        begin
            if (wr_lane0 && hit(adr_i, cbli_pkg::IDX_EDGE_COUNT))
            begin
                edges_q <= cbli_pkg::CNT_ONE;
            end
            else
            begin
                edges_q <= edges_q + cbli_pkg::CNT_ONE;
            end
        end
        else if (wr_lane0 && hit(adr_i, cbli_pkg::IDX_EDGE_COUNT))
        begin
            edges_q <= cbli_pkg::CNT_RESET;
        end
    end

    // one-cycle-late ack; unmapped reads return zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= '0;
        end
        else
        begin
            ack_o <= access;
            dat_o <= '0;
            if (access && !we_i)
            begin
                case (idx)
                    cbli_pkg::IDX_BUS_LINE_CONFIG:
                    begin
                        dat_o[cbli_pkg::CFG_W-1:0] <= cfg_q;
                    end
                    cbli_pkg::IDX_LINE_STATUS:
                    begin
                        dat_o[cbli_pkg::STS_RX_BIT]     <= level_q;
                        dat_o[cbli_pkg::STS_TX_BIT]     <= bus_out_a_o;
                        dat_o[cbli_pkg::STS_BADCFG_BIT] <= badcfg;
                        dat_o[cbli_pkg::STS_STICKY_BIT] <= sticky_q;
                    end
                    cbli_pkg::IDX_EDGE_COUNT:
                    begin
                        dat_o[cbli_pkg::CNT_W-1:0] <= edges_q;
                    end
                    default:
                    begin
                        dat_o <= '0;
                    end
                endcase
            end
        end
    end

endmodule : cbli_line_if
`default_nettype wire

// *** cbli_pkg.sv ***
// Behaviour
// - both receive inputs feed one comparator
// - bypass 0: pos non-inverting, neg inverting
// - pos above neg recessive, neg above pos dominant
// - bypass 1: level taken from pos alone
// - reset default is differential, bypass off
// - recessive: out_a high, out_b low
// - dominant: out_a low, out_b high
`default_nettype none
package cbli_pkg;

    // bus geometry
    localparam int unsigned ADR_W  = 8;
    localparam int unsigned DAT_W  = 32;
    localparam int unsigned IDX_W  = 6;
    localparam int unsigned IDX_LO = 2;

    // register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_BUS_LINE_CONFIG = 6'h2F;
    localparam logic [IDX_W-1:0] IDX_LINE_STATUS     = 6'h30;
    localparam logic [IDX_W-1:0] IDX_EDGE_COUNT      = 6'h31;

    // bus_line_config fields
    localparam int unsigned CFG_W            = 8;
    localparam int unsigned CFG_BYPASS_BIT   = 0;
    localparam int unsigned CFG_DISCONN_BIT  = 1;
    localparam logic [CFG_W-1:0] CFG_RESET   = 8'h00;

    // line_status fields
    localparam int unsigned STS_RX_BIT       = 0;
    localparam int unsigned STS_TX_BIT       = 1;
    localparam int unsigned STS_BADCFG_BIT   = 2;
    localparam int unsigned STS_STICKY_BIT   = 3;

    // edge counter
    localparam int unsigned CNT_W            = 8;
    localparam logic [CNT_W-1:0] CNT_RESET   = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE     = 8'h01;

    // line levels
    localparam logic LVL_RECESSIVE = 1'b1;
    localparam logic LVL_DOMINANT  = 1'b0;

    // synchroniser depth
    localparam int unsigned SYNC_STAGES = 2;

endpackage : cbli_pkg
`default_nettype wire

// *** cbli_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module cbli_sync #(
    parameter int unsigned WIDTH = 2
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // asynchronous inputs and their synchronised copies
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;

    // two flops; the first feeds only the second
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_q <= '0;
            sync_o <= '0;
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule : cbli_sync
`default_nettype wire

// *** cbli_line_if_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module cbli_line_if_asserts (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // line pins
    input wire logic bus_in_pos_i,
    input wire logic bus_in_neg_i,
    input wire logic bus_out_a_o,
    input wire logic bus_out_b_o,
    // protocol side
    input wire logic tx_bit_i,
    input wire logic rx_level_o,
    input wire logic rx_fall_o,
    input wire logic comparator_bypass_o
);
    // one domain, reset masks every check
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // drivers follow the bit one edge later
    tx_rec_a: assert property (tx_bit_i |=> bus_out_a_o && !bus_out_b_o)
        else $error("recessive drive wrong");
    tx_dom_a: assert property (!tx_bit_i |=> !bus_out_a_o && bus_out_b_o)
        else $error("dominant drive wrong");
    // pins held four samples cover the three flop lag
    diff_rec_a: assert property ((!comparator_bypass_o && bus_in_pos_i
        && !bus_in_neg_i) [*4] |-> rx_level_o)
        else $error("differential recessive lost");
    diff_dom_a: assert property ((!comparator_bypass_o && !bus_in_pos_i
        && bus_in_neg_i) [*4] |-> !rx_level_o)
        else $error("differential dominant lost");
    byp_level_a: assert property ((comparator_bypass_o
        && $stable(bus_in_pos_i)) [*4] |-> rx_level_o == bus_in_pos_i)
        else $error("bypass level not from pos");
    // a change must come from the pin three edges back
    rx_lag_a: assert property ($changed(rx_level_o)
        |-> rx_level_o == $past(bus_in_pos_i, 3))
        else $error("receive lag wrong");
    fall_pulse_a: assert property (rx_fall_o
        |-> !rx_level_o && $past(rx_level_o))
        else $error("fall pulse without fall");
    fall_seen_a: assert property ($fell(rx_level_o) |-> rx_fall_o)
        else $error("fall without pulse");
    rst_def_a: assert property ($fell(rst_i)
        |-> !comparator_bypass_o && bus_out_a_o && rx_level_o)
        else $error("reset default wrong");
endmodule : cbli_line_if_asserts

bind cbli_line_if cbli_line_if_asserts cbli_line_if_asserts_inst (
    .clk_i, .rst_i, .bus_in_pos_i, .bus_in_neg_i, .bus_out_a_o,
    .bus_out_b_o, .tx_bit_i, .rx_level_o, .rx_fall_o, .comparator_bypass_o);
`default_nettype wire

// *** cbli_bus_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module cbli_bus_model (
    // clock
    input  wire logic clk_i,
    // device drivers and another node
    input  wire logic out_a_i,
    input  wire logic out_b_i,
    input  wire logic node_dom_i,
    // slow line, noisy negative input
    input  wire logic slow_i,
    input  wire logic noise_i,
    // lines back to the device
    output logic      pos_o,
    output logic      neg_o
);
    logic dom;
    logic dom_q;
    logic tog_q = 1'b0;

    // wired bus: any dominant driver wins
    assign dom = (!out_a_i && out_b_i) || node_dom_i;
    // slow line adds a cycle; noise keeps neg moving
    always_ff @(posedge clk_i)
    begin
        dom_q <= dom;
        tog_q <= !tog_q;
    end
    assign pos_o = slow_i ? !dom_q : !dom;
    assign neg_o = noise_i ? tog_q : (slow_i ? dom_q : dom);
endmodule : cbli_bus_model
`default_nettype wire

// *** cbli_line_if_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module cbli_line_if_test;
    // bench signals; the inputs the bench drives are valued from time zero, the device outputs only after the first edge
    logic        clk_i = 1'b0, rst_i = 1'b1;
    logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0, dat_o, rd_q;
    logic        tx_bit_i = 1'b1, node = 1'b0, slow = 1'b0, noise = 1'b0;
    logic        ack_o, pos, neg, out_a, out_b, rx_level_o, rx_fall_o, byp;
    logic        t, n, lvl, prev;
    int          num_errors = 0, comparisons = 0, edges = 0, i;
    int          falls = 0;

    initial forever #5 clk_i = ~clk_i;

    // count fall pulses as the protocol side would see them
    always @(posedge clk_i)
    begin
        if (rx_fall_o === 1'b1)
            falls++;
    end

    // device and the bus it faces
    cbli_line_if cbli_line_if_inst (
        .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
        .dat_o, .ack_o, .bus_in_pos_i(pos), .bus_in_neg_i(neg),
        .bus_out_a_o(out_a), .bus_out_b_o(out_b), .tx_bit_i,
        .rx_level_o, .rx_fall_o, .comparator_bypass_o(byp));
    cbli_bus_model cbli_bus_model_inst (
        .clk_i, .out_a_i(out_a), .out_b_i(out_b), .node_dom_i(node),
        .slow_i(slow), .noise_i(noise), .pos_o(pos), .neg_o(neg));

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // classic cycle; values read before the edge's updates land
    task automatic wb(input logic        w,
                      input logic [7:0]  a,
                      input logic [31:0] d);
        int k;
        k = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do
        begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 50);
        rd_q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (ack_o !== 1'b1)
        begin
            num_errors++;
            report_and_stop;
        end
        @(posedge clk_i);
    endtask : wb

    // main sequence
    initial
    begin
        void'($urandom(32'hFEA6));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, 8'hBC, 32'h0);
        check("config", rd_q, 32'h0);
        check("bypass", byp, 32'h0);
        $display("reset defaults done");
        // random bits from us and another node, count falls
        wb(1'b1, 8'hC4, 32'h0);
        prev = 1'b1;
        for (i = 0; i < 24; i++)
        begin
            t = 1'($urandom);
            n = 1'($urandom);
            tx_bit_i <= t;
            // other node moves with our driver, so no false gap
            @(posedge clk_i);
            node <= n;
            slow <= 1'($urandom);
            repeat (5) @(posedge clk_i);
            lvl = t && !n;
            if (prev && !lvl)
                edges++;
            prev = lvl;
            check("bus_out_a", out_a, t);
            check("bus_out_b", out_b, !t);
            check("rx_level", rx_level_o, lvl);
        end
        wb(1'b0, 8'hC4, 32'h0);
        check("edge_count", rd_q, edges % 256);
        check("rx_fall count", falls, edges);
        $display("differential traffic done");
        // bypass with the negative input toggling every cycle
        tx_bit_i <= 1'b1;
        wb(1'b1, 8'hBC, 32'h1);
        noise <= 1'b1;
        for (i = 0; i < 8; i++)
        begin
            n = 1'($urandom);
            node <= n;
            repeat (6) @(posedge clk_i);
            check("bypass rx_level", rx_level_o, !n);
        end
        check("bypass", byp, 32'h1);
        noise <= 1'b0;
        node <= 1'b0;
        repeat (6) @(posedge clk_i);
        // pos cut off under bypass must raise both flags
        wb(1'b1, 8'hBC, 32'h3);
        wb(1'b0, 8'hC0, 32'h0);
        check("line_status", rd_q, 32'h0000_000F);
        wb(1'b1, 8'hBC, 32'h0);
        wb(1'b1, 8'hC0, 32'h8);
        wb(1'b0, 8'hC0, 32'h0);
        check("line_status", rd_q, 32'h0000_0003);
        $display("bypass done");
        // stored bits return, upper bits and unmapped read zero
        wb(1'b1, 8'hBC, 32'hFFFF_FFFC);
        wb(1'b0, 8'hBC, 32'h0);
        check("config", rd_q, 32'h0000_00FC);
        wb(1'b1, 8'h10, 32'hFFFF_FFFF);
        wb(1'b0, 8'h10, 32'h0);
        check("unmapped", rd_q, 32'h0);
        $display("registers done");
        report_and_stop;
    end
endmodule : cbli_line_if_test
`default_nettype wire
